// >>> gpt_pkg.sv
package gpt_pkg;

	// ------------------------------------------------------------
	// Timer indices and register map
	// ------------------------------------------------------------
	localparam int GPT_NUM_TIMERS = 5;
	localparam logic [2:0] GPT_T_PRIMARY = 3'h0;
	localparam logic [2:0] GPT_T_A_LOWER = 3'h1;
	localparam logic [2:0] GPT_T_A_UPPER = 3'h2;
	localparam logic [2:0] GPT_T_B_LOWER = 3'h3;
	localparam logic [2:0] GPT_T_B_UPPER = 3'h4;
	// Word address = timer index * 4 + register slot
	localparam logic [1:0] GPT_SLOT_CONTROL = 2'h0;
	localparam logic [1:0] GPT_SLOT_PERIOD = 2'h1;
	localparam logic [1:0] GPT_SLOT_COUNT = 2'h2;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int GPT_RUN_BIT = 15;
	localparam int GPT_IDLE_HALT_BIT = 13;
	localparam int GPT_EXT_SOURCE_HI = 9;
	localparam int GPT_EXT_SOURCE_LO = 8;
	localparam int GPT_GATE_ACCUM_ENABLE = 6;
	localparam int GPT_PRESCALE_HI = 5;
	localparam int GPT_PRESCALE_LO = 4;
	localparam int GPT_PAIR_JOIN_BIT = 3;
	localparam int GPT_EXT_SYNC_SELECT = 2;
	localparam int GPT_CLOCK_SOURCE_BIT = 1;
	localparam logic [15:0] GPT_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] GPT_PERIOD_RESET = 16'hffff;
	// Writable bits; everything else reads as zero
	localparam logic [15:0] GPT_MASK_PRIMARY = 16'ha376;
	localparam logic [15:0] GPT_MASK_LOWER = 16'ha37a;
	localparam logic [15:0] GPT_MASK_UPPER = 16'ha372;

	// ------------------------------------------------------------
	// Extended source codes and prescale terminal counts
	// ------------------------------------------------------------
	localparam logic [1:0] GPT_SRC_GENERIC = 2'h3;
	localparam logic [1:0] GPT_SRC_LOW_POWER_RC_OSC = 2'h2;
	localparam logic [1:0] GPT_SRC_OWN_PIN = 2'h1;
	localparam logic [1:0] GPT_SRC_SECONDARY_OSC = 2'h0;
	localparam logic [7:0] GPT_PSC_DIV1 = 8'h00;
	localparam logic [7:0] GPT_PSC_DIV8 = 8'h07;
	localparam logic [7:0] GPT_PSC_DIV64 = 8'h3f;
	localparam logic [7:0] GPT_PSC_DIV256 = 8'hff;

endpackage

// >>> gpt_timers.sv
`timescale 1ns/1ps
module gpt_timers (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_idle_mode,
	input wire logic i_primary_ext_clock_pin,
	input wire logic [4:0] i_generic_ext_clock_pin,
	input wire logic [1:0] i_upper_ext_clock_pin,
	input wire logic i_low_power_rc_osc,
	input wire logic i_secondary_osc,
	input wire logic [4:0] i_gate,
	output logic [4:0] o_irq,
	output logic o_adc_trigger
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Every register of the block in one word; reset clears all but per (all ones) and wreq (set high)
	typedef struct packed {
		logic [4:0][15:0] con;
		logic [4:0][15:0] per;
		logic [4:0][15:0] cnt;
		logic [4:0][7:0] psc;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] gate_q;
		logic [4:0] irq;
		logic adc;
		logic wreq;
		logic [31:0] rdata;
	} gpt_state_t;

	gpt_state_t q;
	gpt_state_t next_q;
	logic bus_go;
	logic [4:0] join_low;
	logic [4:0] join_up;

	// Pair-join bit lives in the lower control word only
	assign join_low = {1'b0, q.con[3][gpt_pkg::GPT_PAIR_JOIN_BIT], 1'b0, q.con[1][gpt_pkg::GPT_PAIR_JOIN_BIT], 1'b0};
	assign join_up = {q.con[3][gpt_pkg::GPT_PAIR_JOIN_BIT], 1'b0, q.con[1][gpt_pkg::GPT_PAIR_JOIN_BIT], 2'b00};
	// Bus access completes on the cycle waitrequest is low
	assign bus_go = (i_avs_read | i_avs_write) & ~q.wreq;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		logic [15:0] c;
		logic [15:0] mask;
		logic [7:0] lim;
		logic [31:0] w;
		logic [2:0] ti;
		logic [1:0] slot;
		logic [2:0] up;
		logic sel;
		logic edge_e;
		logic run;
		logic tick;
		c = '0;
		mask = '0;
		lim = '0;
		w = '0;
		sel = 1'b0;
		edge_e = 1'b0;
		run = 1'b0;
		tick = 1'b0;
		up = '0;
		ti = i_avs_address[4:2];
		slot = i_avs_address[1:0];
		next_q = q;
		next_q.irq = '0;
		// One pass per timer; a joined upper timer only takes carries
		// Timer indices above four are never decoded here
		for (int t = 0; t < gpt_pkg::GPT_NUM_TIMERS; t++)
		begin
			c = q.con[t];
			// Upper partner, used for joined carry and flags
			up = (t == 1) ? gpt_pkg::GPT_T_A_UPPER : gpt_pkg::GPT_T_B_UPPER;
			run = c[gpt_pkg::GPT_RUN_BIT] & ~(i_idle_mode & c[gpt_pkg::GPT_IDLE_HALT_BIT]);
			// Clock source selection
			unique case (c[gpt_pkg::GPT_EXT_SOURCE_HI:gpt_pkg::GPT_EXT_SOURCE_LO])
				gpt_pkg::GPT_SRC_GENERIC: sel = i_generic_ext_clock_pin[t];
				gpt_pkg::GPT_SRC_LOW_POWER_RC_OSC: sel = i_low_power_rc_osc;
				gpt_pkg::GPT_SRC_OWN_PIN: sel = (t == 0) ? i_primary_ext_clock_pin : i_upper_ext_clock_pin[t >= 3];
				gpt_pkg::GPT_SRC_SECONDARY_OSC: sel = i_secondary_osc;
			endcase
			next_q.src_a[t] = sel;
			next_q.src_b[t] = q.src_a[t];
			// Gate sample kept for the falling-edge flag
			next_q.gate_q[t] = i_gate[t];
			if (c[gpt_pkg::GPT_CLOCK_SOURCE_BIT])
			begin
				// Raw path lets the primary count one stage earlier (async counter)
				if (t == 0 && !c[gpt_pkg::GPT_EXT_SYNC_SELECT])
					edge_e = sel & ~q.src_a[t];
				else
					edge_e = q.src_a[t] & ~q.src_b[t];
			end
			else
			begin
				// Internal clock; gate only matters here
				edge_e = ~c[gpt_pkg::GPT_GATE_ACCUM_ENABLE] | i_gate[t];
			end
			// Gate falling edge ends an accumulation window
			if (!c[gpt_pkg::GPT_CLOCK_SOURCE_BIT] && c[gpt_pkg::GPT_GATE_ACCUM_ENABLE] && run
				&& q.gate_q[t] && !i_gate[t] && !join_up[t])
				next_q.irq[join_low[t] ? up : 3'(t)] = 1'b1;
			// Terminal count is one less than the divide ratio
			unique case (c[gpt_pkg::GPT_PRESCALE_HI:gpt_pkg::GPT_PRESCALE_LO])
				2'h3: lim = gpt_pkg::GPT_PSC_DIV256;
				2'h2: lim = gpt_pkg::GPT_PSC_DIV64;
				2'h1: lim = gpt_pkg::GPT_PSC_DIV8;
				2'h0: lim = gpt_pkg::GPT_PSC_DIV1;
			endcase
			tick = 1'b0;
			// Upper timer of a joined pair has no clock of its own
			if (run && edge_e && !join_up[t])
			begin
				if (q.psc[t] >= lim)
				begin
					next_q.psc[t] = '0;
					tick = 1'b1;
				end
				else
					next_q.psc[t] = q.psc[t] + 8'h01;
			end
			if (tick && join_low[t])
			begin
				// Lower word here, upper word in the partner
				w = {q.cnt[up], q.cnt[t]};
				if (w == {q.per[up], q.per[t]})
				begin
					w = '0;
					next_q.irq[up] = 1'b1;
				end
				else
					w = w + 32'h0000_0001;
				next_q.cnt[up] = w[31:16];
				next_q.cnt[t] = w[15:0];
			end
			else if (tick)
			begin
				if (q.cnt[t] == q.per[t])
				begin
					next_q.cnt[t] = '0;
					next_q.irq[t] = 1'b1;
				end
				else
					next_q.cnt[t] = q.cnt[t] + 16'h0001;
			end
		end
		// Pair B upper flag carries both split and joined matches
		next_q.adc = next_q.irq[gpt_pkg::GPT_T_B_UPPER];
		// Bus: answer one cycle after the request appears
		// Read data is captured early so it stands while waitrequest is low
		next_q.wreq = ~((i_avs_read | i_avs_write) & q.wreq);
		if (i_avs_read && q.wreq)
		begin
			next_q.rdata = '0;
			if (ti <= gpt_pkg::GPT_T_B_UPPER)
			begin
				unique case (slot)
					gpt_pkg::GPT_SLOT_CONTROL: next_q.rdata[15:0] = q.con[ti];
					gpt_pkg::GPT_SLOT_PERIOD: next_q.rdata[15:0] = q.per[ti];
					gpt_pkg::GPT_SLOT_COUNT: next_q.rdata[15:0] = q.cnt[ti];
					default: next_q.rdata = '0;
				endcase
			end
		end
		// Software writes come last, so they win over a tick in the same cycle
		if (bus_go && i_avs_write && ti <= gpt_pkg::GPT_T_B_UPPER)
		begin
			// Byte lanes 0 and 1 carry the 16-bit register
			w = {16'h0000, {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}}};
			if (ti == gpt_pkg::GPT_T_PRIMARY)
				mask = gpt_pkg::GPT_MASK_PRIMARY;
			else if (ti == gpt_pkg::GPT_T_A_LOWER || ti == gpt_pkg::GPT_T_B_LOWER)
				mask = gpt_pkg::GPT_MASK_LOWER;
			else
				mask = gpt_pkg::GPT_MASK_UPPER;
			unique case (slot)
				gpt_pkg::GPT_SLOT_CONTROL:
				begin
					next_q.con[ti] = (q.con[ti] & ~w[15:0]) | (i_avs_writedata[15:0] & w[15:0] & mask);
					// Reconfiguring a running timer restarts its prescaler
					if (q.con[ti][gpt_pkg::GPT_RUN_BIT])
						next_q.psc[ti] = '0;
				end
				gpt_pkg::GPT_SLOT_PERIOD: next_q.per[ti] = (q.per[ti] & ~w[15:0]) | (i_avs_writedata[15:0] & w[15:0]);
				gpt_pkg::GPT_SLOT_COUNT: next_q.cnt[ti] = (q.cnt[ti] & ~w[15:0]) | (i_avs_writedata[15:0] & w[15:0]);
				default: next_q.wreq = next_q.wreq;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Synchronous reset; period registers start at all ones
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_resetn)
		begin
			q <= '0;
			q.per <= {5{gpt_pkg::GPT_PERIOD_RESET}};
			q.con <= {5{gpt_pkg::GPT_CONTROL_RESET}};
			q.wreq <= 1'b1;
		end
		else
			q <= next_q;
	end

	assign o_avs_readdata = q.rdata;
	assign o_avs_waitrequest = q.wreq;
	assign o_irq = q.irq;
	assign o_adc_trigger = q.adc;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	a_run_bit_stop: assert property (!q.con[0][15] && !bus_go |=> $stable(q.cnt[0]))
		else $error("primary count moved while stopped");
	a_idle_halt_hold: assert property (i_idle_mode && q.con[0][13] && !bus_go |=> $stable(q.cnt[0]))
		else $error("primary count moved in idle with halt set");
	a_prescale_terminal: assert property ($changed(q.cnt[0]) && !$past(bus_go) && q.con[0][5:4] == 2'h3
		|-> $past(q.psc[0]) == 8'hff)
		else $error("primary counted before 256 prescaled edges");
	a_gate_blocks_count: assert property (q.con[0][15:1] ==? 15'b1?0?_????_?1??_??0 && !i_gate[0]
		&& !i_idle_mode && !bus_go |=> $stable(q.cnt[0]))
		else $error("gated primary counted with gate low");
	a_ctrl_write_psc: assert property (bus_go && i_avs_write && i_avs_address == 5'h00 && q.con[0][15]
		|=> q.psc[0] == 8'h00)
		else $error("prescaler not cleared by control write");
	a_match_irq_wrap: assert property (q.con[0][15:13] == 3'h4 && q.con[0][6] == 1'b0 && q.con[0][1] == 1'b0
		&& q.con[0][5:4] == 2'h0 && q.cnt[0] == q.per[0] && !bus_go |=> o_irq[0] && q.cnt[0] == 16'h0000)
		else $error("primary match did not flag and wrap");
	a_joined_lower_quiet: assert property (q.con[1][3] && $past(q.con[1][3]) |-> !o_irq[1])
		else $error("joined pair flagged lower timer");
	a_joined_upper_frozen: assert property (q.con[1][3] && !bus_go |=> $stable(q.psc[2]))
		else $error("upper prescaler ran while joined");
	a_adc_from_b: assert property (o_adc_trigger == o_irq[4])
		else $error("trigger not tied to pair B upper flag");
	a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer not one cycle after request");

	// ------------------------------------------------------------
	// Bus checks
	// ------------------------------------------------------------
	// Waitrequest drops for exactly one cycle per access
	a_bus_one_low: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest stayed low");
	// Registers are 16 bits wide, upper half always reads zero
	a_rdata_upper_zero: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");

	// ------------------------------------------------------------
	// Primary timer checks
	// ------------------------------------------------------------
	// A stopped timer must not creep through its prescaler either
	a_stop_psc_frozen: assert property (!q.con[0][15] && !bus_go |=> $stable(q.psc[0]))
		else $error("primary prescaler ran while stopped");
	// Idle without halt keeps the internal count going
	a_idle_runs_on: assert property (q.con[0][15:13] == 3'h4 && i_idle_mode && q.con[0][6:1] == 6'h00
		&& q.cnt[0] != q.per[0] && !bus_go |=> q.cnt[0] == $past(q.cnt[0]) + 16'h0001)
		else $error("primary stalled in idle without halt");
	// Gate falling while gated accumulation runs raises the flag
	a_gate_fall_irq: assert property (q.con[0][15:13] == 3'h4 && q.con[0][6] && !q.con[0][1]
		&& q.gate_q[0] && !i_gate[0] |=> o_irq[0])
		else $error("gate fall did not flag the primary timer");
	// With a prescaler the flag cannot repeat on the next cycle
	a_irq_one_pulse: assert property (o_irq[0] && q.con[0][5:4] != 2'h0 |=> !o_irq[0])
		else $error("primary flag longer than one pulse");

	// ------------------------------------------------------------
	// Pair checks
	// ------------------------------------------------------------
	// Split lower timer wraps on its own period and flags itself
	a_split_lower_wrap: assert property (q.con[3][15] && !q.con[3][13] && q.con[3][6:1] == 6'h00
		&& q.cnt[3] == q.per[3] && !bus_go |=> o_irq[3] && q.cnt[3] == 16'h0000)
		else $error("split lower timer did not wrap and flag");
	// Split upper timer of pair B also drives the trigger
	a_split_upper_wrap: assert property (!q.con[3][3] && q.con[4][15] && !q.con[4][13]
		&& q.con[4][6:1] == 6'h00 && q.cnt[4] == q.per[4] && !bus_go |=> o_irq[4] && o_adc_trigger && q.cnt[4] == 16'h0000)
		else $error("split upper timer did not wrap and trigger");
	// Joined pair carries the lower word into the upper one
	a_joined_carry: assert property (q.con[3][15] && q.con[3][3] && q.con[3][6:4] == 3'h0 && !q.con[3][1]
		&& !q.con[3][13] && q.cnt[3] == 16'hffff && {q.cnt[4], q.cnt[3]} != {q.per[4], q.per[3]} && !bus_go
		|=> q.cnt[3] == 16'h0000 && q.cnt[4] == $past(q.cnt[4]) + 16'h0001)
		else $error("joined pair lost its carry");
	// Only the full 32-bit match flags, and only on the upper flag
	a_joined_full_match: assert property (q.con[3][15] && q.con[3][3] && q.con[3][6:4] == 3'h0 && !q.con[3][1]
		&& !q.con[3][13] && {q.cnt[4], q.cnt[3]} == {q.per[4], q.per[3]} && !bus_go
		|=> o_irq[4] && !o_irq[3] && q.cnt[4] == 16'h0000 && q.cnt[3] == 16'h0000)
		else $error("joined pair match not flagged on upper timer");
	// Pair B upper prescaler sleeps while the pair is joined
	a_joined_b_frozen: assert property (q.con[3][3] && !bus_go |=> $stable(q.psc[4]))
		else $error("pair B upper prescaler ran while joined");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------

	c_primary_match: cover property (o_irq[0]);
	c_pair_a_joined_wrap: cover property (q.con[1][3] && o_irq[2]);
	c_adc_trigger: cover property (o_adc_trigger);
	c_ext_count: cover property (q.con[0][1] && $changed(q.cnt[0]));
	c_split_b_upper: cover property (!q.con[3][3] && o_irq[4]);

endmodule // gpt_timers

// >>> gpt_ext_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// External clock source beside the timers
// ------------------------------------------------------------
module gpt_ext_src (
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire logic [7:0] i_edges,
	input wire logic [3:0] i_half,
	output logic o_clk,
	output logic o_busy
);
	// Burst of rising edges; the line stands low between bursts
	initial
	begin
		o_clk = 1'b0;
		o_busy = 1'b0;
		forever
		begin
			@(posedge i_clk_sys);
			if (i_go)
			begin
				o_busy <= 1'b1;
				// Slow or prompt edges, set by the half period
				repeat (i_edges)
				begin
					repeat (i_half) @(posedge i_clk_sys);
					o_clk <= 1'b1;
					repeat (i_half) @(posedge i_clk_sys);
					o_clk <= 1'b0;
				end
				o_busy <= 1'b0;
			end
		end
	end
endmodule // gpt_ext_src

// >>> tb_gp_timers_with_32bit_pairing.sv
`timescale 1ns/1ps
module tb_gp_timers_with_32bit_pairing;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic clk, rstn, rd, wr, idle, go, wreq, adc, eclk, ebusy, adc_hit;
	logic [4:0] addr, gate, irq;
	logic [31:0] wdata, rdata;
	logic [1:0] osel;
	logic [7:0] edges;
	logic [3:0] half;
	logic [15:0] q;
	int n_fail, cmp_count, cyc, g, w, n3, n3_base;
	gpt_timers uut (.i_clk_sys(clk), .i_resetn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'h3), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_idle_mode(idle), .i_primary_ext_clock_pin(eclk & (osel == 2'h1)),
		.i_generic_ext_clock_pin({4'h0, eclk & (osel == 2'h3)}), .i_upper_ext_clock_pin(2'h0),
		.i_low_power_rc_osc(eclk & (osel == 2'h2)), .i_secondary_osc(eclk & (osel == 2'h0)),
		.i_gate(gate), .o_irq(irq), .o_adc_trigger(adc));
	gpt_ext_src src (.i_clk_sys(clk), .i_go(go), .i_edges(edges), .i_half(half), .o_clk(eclk),
		.o_busy(ebusy));
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard and lower-timer pulse tally
	always @(posedge clk)
	begin
		cyc++;
		if (irq[3] === 1'b1) n3++;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic wn, input logic [4:0] a, input logic [15:0] d);
		int n;
		n = 0;
		wr <= wn;
		rd <= !wn;
		addr <= a;
		wdata <= {16'h0000, d};
		@(posedge clk);
		while (wreq !== 1'b0 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 50)
			n_fail++;
		q = rdata[15:0];
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	// Wait for a pulse (w cycles), then time the gap to the next (g)
	task automatic gap(input int b);
		w = 0;
		while (irq[b] !== 1'b1 && w < 1000)
		begin
			@(posedge clk);
			w++;
		end
		adc_hit = adc;
		@(posedge clk);
		g = 1;
		while (irq[b] !== 1'b1 && g < 1000)
		begin
			@(posedge clk);
			g++;
		end
	endtask
	task automatic stable(input logic s);
		logic [15:0] a;
		bus(1'b0, 5'd2, 16'h0);
		a = q;
		repeat (10) @(posedge clk);
		bus(1'b0, 5'd2, 16'h0);
		chk("hold", q === a, s);
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rd, wr, idle, go, addr, gate, wdata, osel, edges, half} = '0;
		{n_fail, cmp_count, cyc, n3} = '0;
		rstn = 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		// Reset values, writable masks, unmapped places
		bus(1'b0, 5'd0, 16'h0);
		chk("ctrl_rst", q, gpt_pkg::GPT_CONTROL_RESET);
		bus(1'b0, 5'd1, 16'h0);
		chk("per_rst", q, gpt_pkg::GPT_PERIOD_RESET);
		for (int t = 0; t < 3; t++)
		begin
			bus(1'b1, 5'(t * 4), 16'hffff);
			bus(1'b0, 5'(t * 4), 16'h0);
			chk("mask", q, (t == 0) ? gpt_pkg::GPT_MASK_PRIMARY : (t == 1) ? gpt_pkg::GPT_MASK_LOWER :
				gpt_pkg::GPT_MASK_UPPER);
			bus(1'b1, 5'(t * 4), 16'h0);
		end
		bus(1'b1, 5'd3, 16'h1234);
		bus(1'b0, 5'd3, 16'h0);
		chk("unmapped", q, 0);
		bus(1'b0, 5'd20, 16'h0);
		chk("unmapped", q, 0);
		// Period match, prescale codes, prescaler clear on control write
		bus(1'b1, 5'd1, 16'h0004);
		bus(1'b1, 5'd2, 16'h0);
		bus(1'b1, 5'd0, 16'h8000);
		gap(0);
		chk("period", g, 5);
		bus(1'b1, 5'd1, 16'h0);
		bus(1'b1, 5'd2, 16'h0);
		for (int k = 3; k > 0; k--)
		begin
			bus(1'b1, 5'd0, 16'h8000 | 16'(k << 4));
			gap(0);
			chk("psc", g, (k == 3) ? 256 : (k == 2) ? 64 : 8);
		end
		bus(1'b1, 5'd0, 16'h8010);
		gap(0);
		chk("psc_clr", w, 8);
		chk("psc_clr", g, 8);
		// Run bit and idle halt
		bus(1'b1, 5'd1, 16'hffff);
		bus(1'b1, 5'd0, 16'h0);
		stable(1'b1);
		bus(1'b1, 5'd0, 16'ha000);
		idle <= 1'b1;
		stable(1'b1);
		bus(1'b1, 5'd0, 16'h8000);
		stable(1'b0);
		idle <= 1'b0;
		// Gated accumulation and gate-fall interrupt
		bus(1'b1, 5'd0, 16'h8040);
		stable(1'b1);
		gate <= 5'h01;
		stable(1'b0);
		gate <= 5'h00;
		gap(0);
		chk("gate_irq", w < 5, 1);
		// Every extended source, sync and async, prompt and slow edges
		for (int k = 0; k < 4; k++)
		begin
			osel <= 2'(k);
			bus(1'b1, 5'd0, 16'h0);
			bus(1'b1, 5'd2, 16'h0);
			bus(1'b1, 5'd0, 16'h8002 | 16'(k << 8) | 16'((k & 1) << 2));
			edges <= 8'd10;
			half <= 4'(k + 1);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			@(posedge clk);
			for (int n = 0; n < 200 && ebusy; n++) @(posedge clk);
			repeat (4) @(posedge clk);
			bus(1'b0, 5'd2, 16'h0);
			chk("ext_count", q, 10);
		end
		// Joined pair B: carry into upper word, full match, flag on upper
		bus(1'b1, 5'd13, 16'h0002);
		bus(1'b1, 5'd17, 16'h0001);
		bus(1'b1, 5'd14, 16'hfffe);
		bus(1'b1, 5'd18, 16'h0);
		bus(1'b1, 5'd16, 16'h8032);
		n3_base = n3;
		bus(1'b1, 5'd12, 16'h8008);
		gap(4);
		chk("join_irq", w < 12, 1);
		chk("join_adc", adc_hit, 1);
		bus(1'b1, 5'd12, 16'h0008);
		chk("join_lower", n3 - n3_base, 0);
		bus(1'b0, 5'd18, 16'h0);
		chk("join_msw", q, 0);
		bus(1'b0, 5'd14, 16'h0);
		chk("join_lsw", q, 16'h03eb);
		// Split pair B: lower and upper each on their own period
		bus(1'b1, 5'd13, 16'h0003);
		bus(1'b1, 5'd14, 16'h0);
		bus(1'b1, 5'd12, 16'h8000);
		gap(3);
		chk("split_lo", g, 4);
		chk("split_adc", adc_hit, 0);
		bus(1'b1, 5'd17, 16'h0002);
		bus(1'b1, 5'd18, 16'h0);
		bus(1'b1, 5'd16, 16'h8000);
		gap(4);
		chk("split_up", g, 3);
		chk("split_adc", adc_hit, 1);
		stop_test();
	end
endmodule // tb_gp_timers_with_32bit_pairing
